// File: inc/sar_adc_pkg.sv
package sar_adc_pkg;

    // ----------------------------------------------------------------
    // widths and codes
    // ----------------------------------------------------------------
    localparam int RESULT_W  = 10;
    localparam int UPPER_W   = 8;
    localparam int LOWER_W   = 2;
    localparam int UPPER_LSB = 2;
    localparam int BIT_IDX_W = 4;
    localparam logic [RESULT_W-1:0] RESULT_CLEAR = 10'h000;
    localparam logic [RESULT_W-1:0] MID_CODE     = 10'h200;
    localparam logic [BIT_IDX_W-1:0] MSB_IDX     = 4'h9;
    localparam logic [BIT_IDX_W-1:0] LSB_IDX     = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int DONE_RISE_MAX_NS = 1500;
    // longest time: round down
    localparam int DONE_RISE_CYC =
        (DONE_RISE_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        DONE_RISE_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_MIN_NS  = 500;
    localparam int CONV_MIN_CYC =
        (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_WAIT_NS  = 10000;
    localparam int HOLD_WAIT_CYC =
        (HOLD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cycles spent settling before each bit decision; two, so the
    // decision reads the comparator after its two-flop synchroniser
    localparam logic [3:0] SETTLE_CYC = 4'h2;

    // ----------------------------------------------------------------
    // states and carriers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ARMED  = 3'b010,
        ST_CONV   = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic                upper_en_n;
        logic                lower_en_n;
    } byte_en_t;

    typedef struct packed {
        logic [UPPER_W-1:0]  upper;
        logic [UPPER_W-1:0]  upper_oe_n;
        logic [LOWER_W-1:0]  lower;
        logic [LOWER_W-1:0]  lower_oe_n;
    } data_pins_t;

endpackage

// File: hw/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff
    import sar_adc_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk_in,
    input  wire logic   rstn_in,
    // level
    input  wire logic   async_in,
    output logic        sync_out
);
    import sar_adc_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    always_comb
    begin
        state_d.meta = async_in;
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign sync_out = state_q.sync;
endmodule

// File: hw/sar_adc_conversion_control.sv
`timescale 1ns/1ps
module sar_adc_conversion_control
    import sar_adc_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                rstn_in,
    // host control pins
    input  wire logic                convert_in,
    input  wire byte_en_t            byte_en_n_in,
    input  wire logic                offset_open_in,
    // comparator: high when trial code is not above the input
    input  wire logic                compare_keep_in,
    // dac trial code and mode to analogue side
    output logic [RESULT_W-1:0]      dac_code_out,
    output logic                     bipolar_out,
    // status and data pins
    output logic                     conversion_done_n_out,
    output data_pins_t               data_pins_out,
    output logic [RESULT_W-1:0]      result_out
);
    import sar_adc_pkg::*;

    // ----------------------------------------------------------------
    // host pin synchronisers
    // ----------------------------------------------------------------
    logic convert_s;
    logic upper_en_s;
    logic lower_en_s;
    logic offset_open_s;
    logic compare_keep_s;

    sync_2ff u_sync_conv (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (convert_in),
        .sync_out   (convert_s)
    );
    // enables pass inverted, so flops reset to zero read as
    // not driving and no pin turns on just after reset
    sync_2ff u_sync_upper (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (~byte_en_n_in.upper_en_n),
        .sync_out   (upper_en_s)
    );
    sync_2ff u_sync_lower (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (~byte_en_n_in.lower_en_n),
        .sync_out   (lower_en_s)
    );
    sync_2ff u_sync_offs (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (offset_open_in),
        .sync_out   (offset_open_s)
    );

    // ----------------------------------------------------------------
    // comparator synchroniser
    // ----------------------------------------------------------------
    // two cycles of lag here; each trial settles long enough to
    // cover it, else a decision would read the previous trial
    sync_2ff u_sync_cmp (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   (compare_keep_in),
        .sync_out   (compare_keep_s)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        conv_state_t             state;
        logic                    convert_prev;
        logic [RESULT_W-1:0]     approx;
        logic [BIT_IDX_W-1:0]    bit_idx;
        logic [3:0]              settle;
        logic                    done_n;
        logic                    bipolar;
        data_pins_t              pins;
    } ctrl_state_t;

    ctrl_state_t st_q;
    ctrl_state_t st_d;

    // ----------------------------------------------------------------
    // convert edges
    // ----------------------------------------------------------------
    logic conv_rise;
    logic conv_fall;
    logic [RESULT_W-1:0] bit_mask;

    assign conv_rise = convert_s & ~st_q.convert_prev;
    assign conv_fall = ~convert_s & st_q.convert_prev;
    assign bit_mask  = RESULT_W'(1) << st_q.bit_idx;

    // ----------------------------------------------------------------
    // bit stepping
    // ----------------------------------------------------------------
    logic                  settle_done;
    logic                  last_bit;
    logic [BIT_IDX_W-1:0]  next_idx;
    logic [RESULT_W-1:0]   next_mask;
    logic [RESULT_W-1:0]   decided;

    assign settle_done = (st_q.settle == 4'h0);
    assign last_bit    = (st_q.bit_idx == LSB_IDX);
    // wraps past the lsb, but is only used while bits remain
    assign next_idx    = st_q.bit_idx - 4'h1;
    assign next_mask   = RESULT_W'(1) << next_idx;
    // a low comparator means the trial sum overshoots: drop the bit
    assign decided     = compare_keep_s ? st_q.approx
                                        : (st_q.approx & ~bit_mask);

    always_comb
    begin
        st_d = st_q;
        st_d.convert_prev = convert_s;
        // open pin selects bipolar; only sampled between conversions
        if (st_q.state != ST_CONV)
            st_d.bipolar = offset_open_s;
        unique case (st_q.state)
            ST_IDLE:
            begin
                // a fall with no rise before it is ignored here
                if (conv_rise)
                begin
                    st_d.state  = ST_ARMED;
                    st_d.approx = RESULT_CLEAR;
                    st_d.done_n = 1'b1;
                end
            end
            ST_ARMED:
            begin
                // wait for the trailing edge before any decision
                if (conv_fall)
                begin
                    st_d.state   = ST_CONV;
                    st_d.bit_idx = MSB_IDX;
                    st_d.settle  = SETTLE_CYC;
                    st_d.approx  = MID_CODE;                // trial msb
                end
            end
            ST_CONV:
            begin
                if (conv_rise)
                begin
                    // a new pulse aborts the running conversion
                    st_d.state  = ST_ARMED;
                    st_d.approx = RESULT_CLEAR;
                end
                else if (!settle_done)
                    st_d.settle = st_q.settle - 4'h1;
                else if (last_bit)
                begin
                    st_d.approx = decided;
                    st_d.state  = ST_IDLE;
                    st_d.done_n = 1'b0;
                end
                else
                begin
                    // keep or drop this bit, then try the next one
                    st_d.approx  = decided | next_mask;
                    st_d.bit_idx = next_idx;
                    st_d.settle  = SETTLE_CYC;
                end
            end
            default:
                st_d.state = ST_IDLE;
        endcase
        // the code is the same for both modes; bipolar only shifts
        // the analogue input by half scale, so zero reads mid code
        st_d.pins.upper = st_q.approx[RESULT_W-1:UPPER_LSB];
        st_d.pins.lower = st_q.approx[LOWER_W-1:0];
        // enables act at any time, so a read mid-conversion shows
        // the partial code and may clash on a shared bus
        st_d.pins.upper_oe_n = {UPPER_W{~upper_en_s}};
        st_d.pins.lower_oe_n = {LOWER_W{~lower_en_s}};
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_q <= '0;
            st_q.state  <= ST_IDLE;
            st_q.done_n <= 1'b1;
            st_q.pins.upper_oe_n <= '1;
            st_q.pins.lower_oe_n <= '1;
        end
        else
            st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // dac and result share one register: the analogue side sees
    // each trial code on the edge that sets it
    assign dac_code_out          = st_q.approx;
    assign bipolar_out           = st_q.bipolar;
    assign conversion_done_n_out = st_q.done_n;
    assign data_pins_out         = st_q.pins;
    assign result_out            = st_q.approx;
endmodule

// File: dv/sar_adc_props.sv
`timescale 1ns/1ps
module sar_adc_props
    import sar_adc_pkg::*;
(
    // clock, reset and host pins
    input wire logic                sys_clk_in,
    input wire logic                rstn_in,
    input wire logic                convert_in,
    input wire byte_en_t            byte_en_n_in,
    // design outputs
    input wire logic                conversion_done_n_out,
    input wire data_pins_t          data_pins_out,
    input wire logic [RESULT_W-1:0] result_out
);
    import sar_adc_pkg::*;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    done_rise_a: assert property (
        $rose(convert_in) |-> ##[1:15] conversion_done_n_out)
        else $error("done late");
    result_clear_a: assert property (
        convert_in[*5] |-> conversion_done_n_out && result_out == 10'h000)
        else $error("no clear");
    done_fall_a: assert property (
        $fell(convert_in) && conversion_done_n_out |->
        ##[1:60] !conversion_done_n_out)
        else $error("no done");
    result_hold_a: assert property (
        !conversion_done_n_out && !$past(conversion_done_n_out) |->
        $stable(result_out))
        else $error("result moved");
    up_oe_a: assert property (
        $stable(byte_en_n_in.upper_en_n)[*4] |->
        data_pins_out.upper_oe_n == {UPPER_W{byte_en_n_in.upper_en_n}})
        else $error("upper enable");
    lo_oe_a: assert property (
        $stable(byte_en_n_in.lower_en_n)[*4] |->
        data_pins_out.lower_oe_n == {LOWER_W{byte_en_n_in.lower_en_n}})
        else $error("lower enable");
    up_map_a: assert property (
        data_pins_out.upper_oe_n == 8'h00 |->
        data_pins_out.upper == $past(result_out[9:2]))
        else $error("upper map");
    lo_map_a: assert property (
        data_pins_out.lower_oe_n == 2'h0 |->
        data_pins_out.lower == $past(result_out[1:0]))
        else $error("lower map");
    cover property ($fell(conversion_done_n_out));
    cover property (!data_pins_out.lower_oe_n[0] && conversion_done_n_out);
    cover property ($rose(convert_in) && conversion_done_n_out);
endmodule
bind sar_adc_conversion_control sar_adc_props sar_adc_props_i (.sys_clk_in,
    .rstn_in, .convert_in, .byte_en_n_in, .conversion_done_n_out,
    .data_pins_out, .result_out);

// File: dv/adc_front_model.sv
`timescale 1ns/1ps
module adc_front_model
    import sar_adc_pkg::*;
(
    input  wire logic [RESULT_W-1:0] dac_code_in,
    input  wire logic [RESULT_W-1:0] level_in,
    output logic                     keep_out
);
    // ideal comparator: both codings share one ladder, offset is analogue
    assign keep_out = (dac_code_in <= level_in);
endmodule

// File: dv/sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
    import sar_adc_pkg::*;
    logic                sys_clk_in = 1'b0;
    logic                rstn_in = 1'b0;
    logic                convert_in = 1'b0;
    byte_en_t            en_n = 2'b11;
    logic                mode = 1'b0;
    logic                keep;
    logic                done_n;
    logic                bip;
    logic [RESULT_W-1:0] level = 10'h000;
    logic [RESULT_W-1:0] dac;
    logic [RESULT_W-1:0] res;
    data_pins_t          pins;
    logic [9:0]          oe_all;
    int                  failures = 0;
    int                  checks_done = 0;
    logic [9:0]          lv[$] = '{10'h000, 10'h200, 10'h3FE, 10'h3FF};
    sar_adc_conversion_control sar_adc_conversion_control_i (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .convert_in(convert_in),
        .byte_en_n_in(en_n), .offset_open_in(mode), .compare_keep_in(keep),
        .dac_code_out(dac), .bipolar_out(bip),
        .conversion_done_n_out(done_n), .data_pins_out(pins),
        .result_out(res));
    adc_front_model adc_front_model_i (.dac_code_in(dac), .level_in(level),
        .keep_out(keep));
    assign oe_all = {pins.upper_oe_n, pins.lower_oe_n};
    initial
    begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk(input string s, input logic [9:0] e,
                       input logic [9:0] g);
        checks_done++;
        if (e !== g)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_bit(input string s, input logic e, input logic g);
        checks_done++;
        if (e !== g)
        begin
            failures++;
            $display("mismatch %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ev 1 peeks at the pins mid-run, ev 2 restarts mid-run
    task automatic conv(input logic [9:0] v, input logic m, input int ev);
        int n;
        level = v;
        mode = m;
        tick(4);
        convert_in = 1'b1;
        tick(DONE_RISE_CYC);
        chk_bit("done_n", 1'b1, done_n);
        chk("cleared", 10'h000, res);
        convert_in = 1'b0;
        tick(6);
        if (ev == 1)
        begin
            en_n = 2'b00;
            tick(4);
            chk("oe_n", 10'h000, oe_all);
            chk_bit("busy", 1'b1, done_n);
            en_n = 2'b11;
        end
        if (ev == 2)
        begin
            convert_in = 1'b1;
            tick(6);
            chk("restart", 10'h000, res);
            convert_in = 1'b0;
        end
        n = 0;
        while (done_n !== 1'b0 && n < 200)
        begin
            tick(1);
            n++;
        end
        if (done_n !== 1'b0)
        begin
            chk_bit("done_n timeout", 1'b0, done_n);
            close_out();
        end
        chk("result", v, res);
        chk("dac", v, dac);
        chk_bit("mode", m, bip);
        en_n = 2'b01;
        tick(4);
        chk("oe_n", 10'h003, oe_all);
        en_n = 2'b00;
        tick(4);
        chk("upper", {2'h0, v[9:2]}, {2'h0, pins.upper});
        chk("lower", {8'h0, v[1:0]}, {8'h0, pins.lower});
        en_n = 2'b11;
        tick(HOLD_WAIT_CYC);
        chk("held", v, res);
    endtask
    initial
    begin
        void'($urandom(20));
        repeat (4) lv.push_back(10'($urandom));
        repeat (6) @(posedge sys_clk_in);
        #1 rstn_in = 1'b1;
        foreach (lv[i])
            conv(lv[i], i[0], (i > 4) ? i - 4 : 0);
        close_out();
    end
endmodule
